/* File: pacc_pkg.sv */
// Package with register map, field layout, reset values and transfer types of the access checker.
package pacc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index.
  localparam logic [7:0] PAIR_IDX0 = 8'h24;
  localparam logic [7:0] PAIR_IDX1 = 8'h25;
  localparam logic [7:0] PAIR_IDX2 = 8'h26;
  localparam logic [7:0] PAIR_IDX3 = 8'h27;
  localparam logic [7:0] PAIR_IDX4 = 8'h28;
  localparam logic [7:0] PAIR_IDX5 = 8'h2a;
  localparam logic [7:0] PAIR_IDX6 = 8'h2b;
  localparam logic [7:0] PAIR_IDX7 = 8'h2c;
  localparam logic [7:0] PAIR_IDX8 = 8'h2e;
  localparam logic [7:0] REGION_IDX = 8'h30;
  localparam logic [7:0] PRIV_IDX = 8'h20;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h40;
  localparam logic [7:0] IRQ_EN_IDX = 8'h41;
  localparam logic [7:0] IRQ_CLR_IDX = 8'h42;
  localparam int NUM_PAIRS = 9;
  localparam int NUM_MASTERS = 4;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int UPPER_FREEZE_BIT = 7;
  localparam int UPPER_CODE_LSB = 4;
  localparam int LOWER_FREEZE_BIT = 3;
  localparam int LOWER_CODE_LSB = 0;
  localparam int REGION_FREEZE_BIT = 7;
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam logic [7:0] REGION_RESET = 8'h00;
  localparam logic [3:0] PRIV_RESET = 4'h1;
  localparam logic [2:0] CODE_DENY_ALL = 3'h7;
  localparam int REGION_MSB = 25;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ------------------------------------------------------------
  // Transfer and verdict types
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [1:0] master;
    logic supervisor;
    logic fetch;
    logic write;
    logic [29:0] offset;
  } pacc_xfer_t;

  typedef struct packed {
    logic valid;
    logic allow;
    logic error;
    logic [4:0] target;
  } pacc_verdict_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
  } pacc_rights_t;

endpackage

/* File: pacc_checker.sv */
// Peripheral access checker: guard registers on APB plus transfer rights verdicts.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Functional notes
// ------------------------------------------------------------
module pacc_checker (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] pmaster,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trusted-master straps and module selectors
  input wire logic [pacc_pkg::NUM_MASTERS-1:0] trusted_in,
  input wire logic [4:0] xfer_module,
  input wire pacc_pkg::pacc_xfer_t xfer,
  // Verdict and interrupt
  output pacc_pkg::pacc_verdict_t verdict,
  output logic irq
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic pacc_pkg::pacc_rights_t code3(input logic [2:0] c, input logic s);
    pacc_pkg::pacc_rights_t r;
    r = '0;
    case (c)
      3'h0: r = '{rd: s, wr: s, ex: 1'b0};
      3'h1, 3'h3: r = '{rd: s, wr: 1'b0, ex: 1'b0};
      3'h2: r = '{rd: 1'b1, wr: 1'b0, ex: 1'b0};
      3'h4, 3'h6: r = '{rd: 1'b1, wr: 1'b1, ex: 1'b0};
      3'h5: r = '{rd: 1'b1, wr: s, ex: 1'b0};
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic pacc_pkg::pacc_rights_t code4(input logic [3:0] c, input logic s);
    pacc_pkg::pacc_rights_t r;
    r = '0;
    case (c)
      4'h8: r = '{rd: s, wr: s, ex: s};
      4'h9: r = '{rd: s, wr: 1'b0, ex: s};
      4'ha: r = '{rd: 1'b1, wr: 1'b0, ex: 1'b1};
      4'hb: r = '{rd: 1'b0, wr: 1'b0, ex: s};
      4'hc: r = '{rd: 1'b1, wr: 1'b1, ex: 1'b1};
      4'hd: r = '{rd: 1'b1, wr: s, ex: 1'b1};
      4'he: r = '{rd: 1'b1, wr: s, ex: 1'b0};
      4'hf: r = '{rd: s, wr: s, ex: 1'b1};
      default: r = code3(c[2:0], s);
    endcase
    return r;
  endfunction

  // Returns the pair slot for an index, or NUM_PAIRS for no pair register.
  function automatic logic [3:0] pair_slot(input logic [7:0] idx);
    logic [3:0] s;
    s = 4'h9;
    case (idx)
      pacc_pkg::PAIR_IDX0: s = 4'h0;
      pacc_pkg::PAIR_IDX1: s = 4'h1;
      pacc_pkg::PAIR_IDX2: s = 4'h2;
      pacc_pkg::PAIR_IDX3: s = 4'h3;
      pacc_pkg::PAIR_IDX4: s = 4'h4;
      pacc_pkg::PAIR_IDX5: s = 4'h5;
      pacc_pkg::PAIR_IDX6: s = 4'h6;
      pacc_pkg::PAIR_IDX7: s = 4'h7;
      pacc_pkg::PAIR_IDX8: s = 4'h8;
      default: s = 4'h9;
    endcase
    return s;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] pair_guard [pacc_pkg::NUM_PAIRS];
  logic [7:0] region_guard;
  logic [3:0] master_privilege_bits;
  logic [pacc_pkg::NUM_MASTERS-1:0] trusted_meta;
  logic [pacc_pkg::NUM_MASTERS-1:0] trusted;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [1:0] strap_wait;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire logic [7:0] idx = paddr[9:2];
  wire logic [3:0] slot = pair_slot(idx);
  wire logic is_pair = (slot != 4'h9);
  wire logic is_region = (idx == pacc_pkg::REGION_IDX);
  wire logic is_priv = (idx == pacc_pkg::PRIV_IDX);
  wire logic is_stat = (idx == pacc_pkg::IRQ_STAT_IDX);
  wire logic is_en = (idx == pacc_pkg::IRQ_EN_IDX);
  wire logic is_clr = (idx == pacc_pkg::IRQ_CLR_IDX);
  wire logic is_guard = is_pair | is_region | is_priv;
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable & pready;
  wire logic [7:0] sel_pair = is_pair ? pair_guard[slot] : 8'h00;
  wire logic pair_frozen = sel_pair[pacc_pkg::UPPER_FREEZE_BIT]
                         | sel_pair[pacc_pkg::LOWER_FREEZE_BIT];
  wire logic region_frozen = region_guard[pacc_pkg::REGION_FREEZE_BIT];
  wire logic untrusted = is_guard & ~trusted[pmaster];
  wire logic frozen_hit = (is_pair & pair_frozen) | (is_region & region_frozen);
  wire logic wr_err = pwrite & (untrusted | frozen_hit);
  wire logic wr_ok = access & pwrite & ~wr_err;
  wire logic wr_denied = access & pwrite & wr_err;
  wire logic [31:0] rd_val = is_pair ? {24'h0, sel_pair}
                           : is_region ? {24'h0, region_guard[7], 3'h0, region_guard[3:0]}
                           : is_priv ? {28'h0, master_privilege_bits}
                           : is_stat ? {30'h0, irq_status}
                           : is_en ? {30'h0, irq_enable}
                           : 32'h0;

  // ------------------------------------------------------------
  // Transfer check
  // ------------------------------------------------------------
  wire logic eff_super = xfer.supervisor & master_privilege_bits[xfer.master];
  wire logic in_region = (xfer.offset[29:pacc_pkg::REGION_MSB+1] == '0);
  wire logic mod_pair = (xfer_module < 5'd18) & (xfer_module != 5'd7);
  wire logic [3:0] mod_slot = 4'(xfer_module[4:1]);
  wire logic [7:0] mod_reg = mod_pair ? pair_guard[mod_slot] : 8'h00;
  wire logic [2:0] mod_code = xfer_module[0] ? mod_reg[2:0] : mod_reg[6:4];
  wire pacc_pkg::pacc_rights_t pair_r = code3(mod_code, eff_super);
  wire pacc_pkg::pacc_rights_t grp_r = code4(region_guard[3:0], eff_super);
  wire pacc_pkg::pacc_rights_t use_r = mod_pair ? pair_r : grp_r;
  wire logic granted = in_region & (xfer.fetch ? (use_r.ex & ~mod_pair)
                     : xfer.write ? use_r.wr : use_r.rd);
  wire logic denied_evt = xfer.valid & ~granted;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pacc_pkg::NUM_PAIRS; i++) begin
        pair_guard[i] <= pacc_pkg::PAIR_RESET;
      end
      region_guard <= pacc_pkg::REGION_RESET;
    end else if (wr_ok & is_pair) begin
      pair_guard[slot] <= pwdata[7:0];
    end else if (wr_ok & is_region) begin
      region_guard <= {pwdata[7], 3'h0, pwdata[3:0]};
    end
  end

  // Straps pass two flip-flops first, so the privilege bits never see a raw pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trusted_meta <= '0;
      trusted <= '0;
      master_privilege_bits <= pacc_pkg::PRIV_RESET;
      strap_wait <= 2'h0;
    end else begin
      trusted_meta <= trusted_in;
      trusted <= {trusted_meta[3:1], 1'b1};
      if (strap_wait != 2'h3) begin
        strap_wait <= strap_wait + 2'h1;
      end
      if (strap_wait == pacc_pkg::STRAP_SETTLE) begin
        master_privilege_bits <= {trusted[3:1], 1'b1};
      end else if (wr_ok & is_priv) begin
        master_privilege_bits <= pwdata[3:0];
      end
    end
  end

  // Status bit 0 is a denied transfer, bit 1 a refused register write; set wins over clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~((access & pwrite & is_clr) ? pwdata[1:0] : 2'h0))
                  | {wr_denied, denied_evt};
      if (access & pwrite & is_en) begin
        irq_enable <= pwdata[1:0];
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  // ------------------------------------------------------------
  // APB answer and verdict
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      verdict <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & wr_err;
      prdata <= (setup & ~pwrite) ? rd_val : 32'h0;
      verdict.valid <= xfer.valid;
      verdict.allow <= xfer.valid & granted;
      verdict.error <= denied_evt;
      verdict.target <= xfer_module;
    end
  end

endmodule

/* File: pacc_props.sv */
// Port assertions for the peripheral access checker.
`timescale 1ns/1ps
module pacc_props (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Transfer side
  input wire logic [4:0] xfer_module,
  input wire pacc_pkg::pacc_xfer_t xfer,
  input wire pacc_pkg::pacc_verdict_t verdict
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic pair_mod;
  assign pair_mod = (xfer_module < 5'd18) && (xfer_module != 5'd7);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  verdict_follows_a: assert property (xfer.valid |=> verdict.valid)
    else $error("no verdict");
  no_spurious_verdict_a: assert property (!xfer.valid |=> !verdict.valid)
    else $error("verdict without transfer");
  allow_or_error_a: assert property (verdict.valid |-> verdict.allow ^ verdict.error)
    else $error("verdict not exclusive");
  fetch_pair_a: assert property (xfer.valid && xfer.fetch && pair_mod |=> verdict.error)
    else $error("fetch to pair module allowed");
  far_region_a: assert property (xfer.valid && xfer.offset[29:26] != 4'h0 |=> verdict.error)
    else $error("far region allowed");
  hole_read_a: assert property (psel && !penable && !pwrite && (paddr == 12'ha4 || paddr == 12'hb4)
    |=> prdata == 32'h0)
    else $error("hole read not zero");
endmodule
bind pacc_checker pacc_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .xfer_module, .xfer, .verdict);

/* File: pacc_master.sv */
// Bus master model that issues single-cycle transfers to the checker.
`timescale 1ns/1ps
module pacc_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the bench
  input wire logic go,
  input wire pacc_pkg::pacc_xfer_t req,
  input wire logic [4:0] req_mod,
  // Transfer towards the checker
  output pacc_pkg::pacc_xfer_t xfer,
  output logic [4:0] xfer_module
);
  // Idle attributes keep toggling, so a stale request is never read as a live one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer <= '0;
      xfer_module <= '0;
    end else begin
      xfer <= go ? req : {1'b0, ~xfer[34:0]};
      xfer_module <= go ? req_mod : ~xfer_module;
    end
  end
endmodule

/* File: testbench.sv */
// Self-checking bench for the peripheral access checker.
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] pmaster = '0;
  logic [3:0] trusted_in = 4'h2;
  logic [4:0] req_mod = '0, xfer_module;
  logic err, irq, pready, pslverr;
  bit den = 0;
  pacc_pkg::pacc_xfer_t req = '0, xfer;
  pacc_pkg::pacc_verdict_t verdict;
  int mismatches = 0, checks = 0, pg[9], rg;
  int gtab[16] = '{'h30, 'h20, 'h24, 'h20, 'h36, 'h34, 'h36, 0, 'h38, 'h28, 'h2d, 'h08, 'h3f,
    'h3d, 'h34, 'h39};
  logic [7:0] pidx[9] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h2e};
  pacc_checker i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pmaster,
    .prdata, .pready, .pslverr, .trusted_in, .xfer_module, .xfer, .verdict, .irq);
  pacc_master i_far (.pclk, .presetn, .go, .req, .req_mod, .xfer, .xfer_module);
  initial forever #5 pclk = ~pclk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(bit w, logic [7:0] i, logic [7:0] d, logic [1:0] m);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b0, i, 2'b0};
    pwdata <= {24'h0, d};
    pmaster <= m;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] d, logic [1:0] m);
    bit bad = 1'b0;
    apb(1, i, d, m);
    if (i == 8'h30) begin
      bad = m[1] | rg[7];
      if (!bad) rg = d & 8'h8f;
    end else for (int k = 0; k < 9; k++) if (pidx[k] == i) begin
      bad = m[1] | pg[k][7] | pg[k][3];
      if (!bad) pg[k] = d;
    end
    chk("write error", err, bad);
  endtask
  task automatic rdchk(logic [7:0] i);
    int v = (i == 8'h30) ? rg : 0;
    foreach (pidx[k]) if (pidx[k] == i) v = pg[k];
    apb(0, i, 8'h00, 2'h0);
    chk("read", rd, v);
  endtask
  task automatic xf();
    logic [4:0] md = 5'($urandom % 20);
    pacc_pkg::pacc_xfer_t q;
    int c, s;
    bit pr, a;
    q = {1'b1, 2'($urandom), 3'($urandom),
      ($urandom % 4 == 0) ? 30'($urandom) : 30'($urandom % 1024)};
    pr = md < 18 && md != 7;
    c = pr ? (pg[md / 2] >> (md[0] ? 0 : 4)) & 7 : rg & 15;
    s = (q.supervisor && q.master < 2) ? 3 : 0;
    a = q.offset[29:26] == 0 && !(pr && q.fetch) && gtab[c][s + (q.fetch ? 0 : q.write ? 1 : 2)];
    den |= !a;
    @(posedge pclk);
    req <= q;
    req_mod <= md;
    go <= 1;
    @(posedge pclk) go <= 0;
    repeat (2) @(posedge pclk);
    chk("verdict", {verdict.valid, verdict.allow, verdict.error}, {1'b1, a, !a});
    chk("target", verdict.target, md);
  endtask
  task automatic do_reset();
    presetn <= 0;
    rg = 0;
    pg = '{default: 0};
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h1408));
    do_reset();
    foreach (pidx[k]) rdchk(pidx[k]);
    rdchk(8'h30);
    wr(8'h29, 8'hff, 0);
    rdchk(8'h29);
    rdchk(8'h2d);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      wr(8'h30, {1'b0, 3'($urandom), 4'(c)}, 0);
      wr(pidx[c % 9], {1'b0, 3'(c), 1'b0, 3'(c + 3)}, 2'(c % 2));
      rdchk(8'h30);
      repeat (8) xf();
    end
    $display("test rights done");
    apb(0, 8'h40, 0, 0);
    chk("status denied", rd, 32'(den));
    wr(8'h42, 8'h03, 0);
    apb(0, 8'h40, 0, 0);
    chk("status clear", rd, 0);
    wr(8'h41, 8'h03, 0);
    wr(8'h24, 8'h11, 2);
    apb(0, 8'h40, 0, 0);
    chk("status", rd, 2);
    chk("irq", irq, 1);
    wr(8'h41, 8'h00, 0);
    apb(0, 8'h40, 0, 0);
    chk("irq masked", irq, 0);
    wr(8'h42, 8'h03, 0);
    rdchk(8'h24);
    wr(8'h27, 8'h8c, 1);
    wr(8'h27, 8'h00, 0);
    rdchk(8'h27);
    wr(8'h30, 8'h8c, 0);
    wr(8'h30, 8'h00, 0);
    rdchk(8'h30);
    repeat (8) xf();
    do_reset();
    rdchk(8'h27);
    rdchk(8'h30);
    repeat (8) xf();
    $display("test trust freeze done");
    stop_test();
  end
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
